/* File: dpr_ram_device.sv */
`timescale 1ns/100ps
`default_nettype none
module dpr_ram_device
  import dpr_pkg::*;
(
  input  wire logic sys_clk,   // Port clock shared by both ports.
  input  wire logic rst,       // Synchronous reset, active high.
  dpr_if.dev        leftPort,  // Port 0.
  dpr_if.dev        rightPort  // Port 1.
);

  // ------------------------------------------------------------------
  // Pin gathering
  // ------------------------------------------------------------------
  // Both ports go into indexed arrays so that one generate body serves.
  logic [1:0][ADDR_W-1:0] addrIn;       // Address pins seen.
  logic [1:0][DATA_W-1:0] dataIn;       // Data pins seen.
  logic [1:0]             strobeN;      // Address strobes.
  logic [1:0]             csLowN;       // First chip enables.
  logic [1:0]             csHigh;       // Second chip enables.
  logic [1:0]             advanceN;     // Counter advance inputs.
  logic [1:0]             clearN;       // Counter clear inputs.
  logic [1:0]             maskSelN;     // Mask select inputs.
  logic [1:0]             rwN;          // Read/write selects.
  logic [1:0]             oeN;          // Output enables.
  logic [1:0][LANES-1:0]  laneN;        // Byte lane selects.
  wire                    mclrN;        // Combined master clear.

  assign addrIn   = {rightPort.addrBus, leftPort.addrBus};
  assign dataIn   = {rightPort.dataBus, leftPort.dataBus};
  assign strobeN  = {rightPort.addrStrobeN, leftPort.addrStrobeN};
  assign csLowN   = {rightPort.chipSelLowN, leftPort.chipSelLowN};
  assign csHigh   = {rightPort.chipSelHigh, leftPort.chipSelHigh};
  assign advanceN = {rightPort.countAdvanceN, leftPort.countAdvanceN};
  assign clearN   = {rightPort.counterClearN, leftPort.counterClearN};
  assign maskSelN = {rightPort.maskSelectN, leftPort.maskSelectN};
  assign rwN      = {rightPort.readWriteN, leftPort.readWriteN};
  assign oeN      = {rightPort.outEnableN, leftPort.outEnableN};
  assign laneN    = {rightPort.byteLaneSelN, leftPort.byteLaneSelN};
  // One pin serves the whole part; each host copy may pull it low.
  assign mclrN = leftPort.masterClearN & rightPort.masterClearN;

  // Per-port results handed between the port bodies and the array.
  logic [1:0][ADDR_W-1:0] accAddr;      // Address of this cycle's access.
  logic [1:0]             wrEn;         // Write this cycle.
  logic [1:0]             rdEn;         // Read this cycle.
  logic [1:0]             anyLane;      // At least one lane selected.
  logic [1:0][ADDR_W-1:0] rbAddr;       // Readback address register.
  logic [1:0]             rbOe;         // Readback drive register.
  logic [1:0][DATA_W-1:0] rdData;       // Read data register.
  logic [1:0]             rdValid;      // Read data waiting on the pins.
  logic [1:0]             mboxFlagN;    // Mailbox flags.
  logic [1:0]             wrapN;        // Wrap flags.

  // The array itself; eighteen address bits give the full depth.
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ------------------------------------------------------------------
  // Array write
  // ------------------------------------------------------------------
  // Same-word writes from both ports are the host's to avoid; the right
  // port lands last here, which is as good as any undefined answer.
  always_ff @(posedge sys_clk) begin
    for (int q = 0; q < 2; q++) begin
      for (int l = 0; l < LANES; l++) begin
        if (wrEn[q] && !laneN[q][l]) begin
          mem[accAddr[q]][l*LANE_W +: LANE_W] <=
            dataIn[q][l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Port logic
  // ------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [ADDR_W-1:0] cnt;        // Burst address counter.
    logic [ADDR_W-1:0] mask;       // Counter mask, ones count.
    wire               selected;   // Both chip enables asserted.
    wire               maskMode;   // Controls aimed at the mask.
    wire               doClear;    // Clear sampled low.
    wire               doLoad;     // Strobe with advance low.
    wire               doReadBack; // Strobe low with advance high.
    wire               doStep;     // Advance low, nothing else.
    wire [ADDR_W-1:0]  stepVal;    // Counter after one step.
    wire [ADDR_W-1:0]  ownMbox;    // This port's mailbox address.
    wire [ADDR_W-1:0]  farMbox;    // The other port's mailbox address.
    wire               farWrite;   // Other port writes our mailbox.
    wire               ownRead;    // We read our own mailbox.
    wire               wrapHit;    // Step fills the unmasked bits.

    assign selected   = !csLowN[p] && csHigh[p];
    assign maskMode   = !maskSelN[p];
    assign doClear    = !clearN[p];
    assign doLoad     = clearN[p] && !strobeN[p] && !advanceN[p];
    assign doReadBack = clearN[p] && !strobeN[p] && advanceN[p];
    // Strobe or clear low wins over the advance input.
    assign doStep = !maskMode && clearN[p] && strobeN[p]
                    && !advanceN[p];
    // Filling the masked bits with ones lets the carry pass over them,
    // so a cleared bit 0 makes the counter step by two.
    assign stepVal = (((cnt | ~mask) + 18'h00001) & mask)
                     | (cnt & ~mask);
    assign wrapHit = doStep && ((stepVal | ~mask) == ADDR_ONES);

    // Access uses the strobed address, otherwise the counter.
    assign accAddr[p] = strobeN[p] ? cnt : addrIn[p];
    assign anyLane[p] = !(&laneN[p]);
    assign wrEn[p]    = selected && !rwN[p];
    assign rdEn[p]    = selected && rwN[p];

    assign ownMbox  = (p == 0) ? MBOX_LEFT : MBOX_RIGHT;
    assign farMbox  = (p == 0) ? MBOX_RIGHT : MBOX_LEFT;
    // A mailbox event needs at least one live byte lane.
    assign farWrite = wrEn[1-p] && anyLane[1-p]
                      && (accAddr[1-p] == ownMbox);
    assign ownRead  = rdEn[p] && anyLane[p] && (accAddr[p] == ownMbox);

    // Counter and mask. Master clear is asynchronous and only ever loads
    // constants; the system reset does the same on the clock.
    always_ff @(posedge sys_clk or negedge mclrN) begin
      if (!mclrN || rst) begin
        cnt  <= CNT_RESET;
        mask <= MASK_RESET;
      end else if (maskMode) begin
        // Mask access; the counter rests meanwhile.
        if (doClear) begin
          mask <= MASK_RESET;
        end else if (doLoad) begin
          mask <= addrIn[p];
        end
      end else if (doClear) begin
        cnt <= cnt & ~mask;
      end else if (doLoad) begin
        cnt <= addrIn[p];
      end else if (doStep) begin
        cnt <= stepVal;
      end
    end

    // Readback drives the address pins for the following cycle.
    always_ff @(posedge sys_clk or negedge mclrN) begin
      if (!mclrN || rst) begin
        rbAddr[p] <= CNT_RESET;
        rbOe[p]   <= 1'b0;
      end else begin
        rbAddr[p] <= maskMode ? mask : cnt;
        rbOe[p]   <= doReadBack;
      end
    end

    // Pipelined read: word registered at the edge, shown the next cycle.
    // Lanes that were not selected read back as zero.
    always_ff @(posedge sys_clk or negedge mclrN) begin
      if (!mclrN || rst) begin
        rdData[p]  <= '0;
        rdValid[p] <= 1'b0;
      end else begin
        rdValid[p] <= rdEn[p];
        for (int l = 0; l < LANES; l++) begin
          rdData[p][l*LANE_W +: LANE_W] <= laneN[p][l] ? 9'h000 :
            mem[accAddr[p]][l*LANE_W +: LANE_W];
        end
      end
    end

    // Mailbox flag: a write from the far side sets it (low) and beats a
    // simultaneous read by the owner, so no message is lost.
    always_ff @(posedge sys_clk or negedge mclrN) begin
      if (!mclrN || rst) begin
        mboxFlagN[p] <= 1'b1;
      end else if (farWrite) begin
        mboxFlagN[p] <= 1'b0;
      end else if (ownRead) begin
        mboxFlagN[p] <= 1'b1;
      end
    end

    // Wrap flag stays low until the counter is cleared or loaded.
    always_ff @(posedge sys_clk or negedge mclrN) begin
      if (!mclrN || rst) begin
        wrapN[p] <= 1'b1;
      end else if (wrapHit) begin
        wrapN[p] <= 1'b0;
      end else if (!maskMode && (doClear || doLoad)) begin
        wrapN[p] <= 1'b1;
      end
    end
  end : g_port

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Output enable acts without the clock, so it gates the registered
  // read data directly; the address readback and the mailbox flag release on a read ignore it.
  assign leftPort.dataDevOe  = rdValid[0] && !oeN[0];
  assign rightPort.dataDevOe = rdValid[1] && !oeN[1];
  assign leftPort.dataDev    = rdData[0];
  assign rightPort.dataDev   = rdData[1];
  assign leftPort.addrDev    = rbAddr[0];
  assign rightPort.addrDev   = rbAddr[1];
  assign leftPort.addrDevOe  = rbOe[0];
  assign rightPort.addrDevOe = rbOe[1];
  assign leftPort.mailboxFlagN  = mboxFlagN[0];
  assign rightPort.mailboxFlagN = mboxFlagN[1];
  assign leftPort.wrapFlagN  = wrapN[0];
  assign rightPort.wrapFlagN = wrapN[1];

endmodule : dpr_ram_device
`default_nettype wire

/* File: dpr_pkg.sv */
`default_nettype none
package dpr_pkg;
  // --------------------------------------------------------------------
  // Array geometry
  // --------------------------------------------------------------------
  localparam int ADDR_W = 18;                    // Largest density.
  localparam int DATA_W = 36;                    // Four lanes of nine.
  localparam int LANE_W = 9;                     // Bits per byte lane.
  localparam int LANES  = 4;                     // Byte lanes per word.
  localparam logic [ADDR_W-1:0] ADDR_ONES = {ADDR_W{1'b1}};
  // Mailboxes: top word belongs to the right port, next to the left.
  localparam logic [ADDR_W-1:0] MBOX_LEFT  = ADDR_ONES - 18'h00001;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT = ADDR_ONES;
  // Values after reset.
  localparam logic [ADDR_W-1:0] CNT_RESET  = 18'h00000;
  localparam logic [ADDR_W-1:0] MASK_RESET = ADDR_ONES;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;              // 200 MHz system clock.
  localparam int MCLR_TIME_NS  = 100;            // Least master clear.
  localparam int MCLR_CYCLES   =
    (MCLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------------
  // Controller register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0] REG_PINS     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_WDATA    = 8'h08;
  localparam logic [7:0] REG_WDATA_HI = 8'h0c;
  localparam logic [7:0] REG_GO       = 8'h10;
  localparam logic [7:0] REG_RDATA    = 8'h14;
  localparam logic [7:0] REG_RDATA_HI = 8'h18;
  localparam logic [7:0] REG_RBADDR   = 8'h1c;
  localparam logic [7:0] REG_STATUS   = 8'h20;
  // Field positions of the pin image register.
  localparam int PIN_STROBE  = 0;
  localparam int PIN_ADVANCE = 1;
  localparam int PIN_CLEAR   = 2;
  localparam int PIN_MASKSEL = 3;
  localparam int PIN_RW      = 4;
  localparam int PIN_OE      = 5;
  localparam int PIN_LANE    = 6;                // Four bits wide.
  localparam int PIN_CSLOW   = 10;
  localparam int PIN_CSHIGH  = 11;
  localparam int PIN_MCLR    = 12;
  localparam logic [12:0] PINS_RESET = 13'h1fff;
endpackage : dpr_pkg
`default_nettype wire

/* File: dpr_if.sv */
`timescale 1ns/100ps
`default_nettype none
// One synchronous port of the dual-port RAM; the host drives it.
interface dpr_if;
  import dpr_pkg::*;
  logic [ADDR_W-1:0] addrHost;        // Address driven by the host.
  logic              addrHostOe;      // Host drives the address pins.
  logic [ADDR_W-1:0] addrDev;         // Readback driven by the device.
  logic              addrDevOe;       // Device drives the address pins.
  logic [DATA_W-1:0] dataHost;        // Write data from the host.
  logic              dataHostOe;      // Host drives the data pins.
  logic [DATA_W-1:0] dataDev;         // Read data from the device.
  logic              dataDevOe;       // Device drives the data pins.
  logic              addrStrobeN;     // Address strobe, active low.
  logic              chipSelLowN;     // First chip enable, active low.
  logic              chipSelHigh;     // Second chip enable, active high.
  logic              countAdvanceN;   // Counter advance, active low.
  logic              counterClearN;   // Counter clear, active low.
  logic              maskSelectN;     // Mask register select, active low.
  logic              readWriteN;      // High reads, low writes.
  logic              outEnableN;      // Output enable, active low.
  logic [LANES-1:0]  byteLaneSelN;    // Byte lane selects, active low.
  logic              masterClearN;    // Master clear, active low.
  logic              mailboxFlagN;    // Mailbox flag, active low.
  logic              wrapFlagN;       // Counter wrap flag, active low.
  // Resolved pin levels; the device owns the wire while its driver is enabled, the host otherwise.
  logic [ADDR_W-1:0] addrBus;
  logic [DATA_W-1:0] dataBus;
  assign addrBus = addrDevOe ? addrDev : addrHost;
  assign dataBus = dataDevOe ? dataDev : dataHost;

  modport dev (
    input  addrBus, dataBus, addrStrobeN, chipSelLowN, chipSelHigh,
           countAdvanceN, counterClearN, maskSelectN, readWriteN,
           outEnableN, byteLaneSelN, masterClearN,
    output addrDev, addrDevOe, dataDev, dataDevOe, mailboxFlagN, wrapFlagN
  );
  modport host (
    input  addrBus, dataBus, addrDevOe, dataDevOe, mailboxFlagN, wrapFlagN,
    output addrHost, addrHostOe, dataHost, dataHostOe, addrStrobeN,
           chipSelLowN, chipSelHigh, countAdvanceN, counterClearN,
           maskSelectN, readWriteN, outEnableN, byteLaneSelN, masterClearN
  );
endinterface : dpr_if
`default_nettype wire

/* File: dpr_port_host.sv */
`timescale 1ns/100ps
`default_nettype none
module dpr_port_host
  import dpr_pkg::*;
(
  input  wire logic        sys_clk,    // System clock.
  input  wire logic        rst,        // Synchronous reset, active high.
  input  wire logic [7:0]  regAddr,    // Register byte address.
  input  wire logic [31:0] regWrData,  // Register write data.
  input  wire logic        regWr,      // Write strobe.
  input  wire logic        regRd,      // Read strobe.
  output logic      [31:0] regRdData,  // Read data, cycle after strobe.
  dpr_if.host              link        // The RAM port.
);

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  logic [12:0]       pins;        // Pin image for the next cycle.
  logic [ADDR_W-1:0] addrReg;     // Address to present.
  logic [DATA_W-1:0] wdata;       // Word to write.
  logic [DATA_W-1:0] rdataReg;    // Last word read back.
  logic [ADDR_W-1:0] rbReg;       // Last address readback.
  logic [7:0]        mclrCnt;     // Master clear pulse counter.
  logic              mclrDone;    // Power-up clear finished.
  wire               wrPins;      // Decoded writes.
  wire               wrAddr;
  wire               wrData;
  wire               wrDataHi;
  wire               go;          // Launch one port cycle.
  wire  [31:0]       rdMux;       // Selected read value.

  assign wrPins   = regWr && (regAddr == REG_PINS);
  assign wrAddr   = regWr && (regAddr == REG_ADDR);
  assign wrData   = regWr && (regAddr == REG_WDATA);
  assign wrDataHi = regWr && (regAddr == REG_WDATA_HI);
  assign go       = regWr && (regAddr == REG_GO);

  // Unmapped addresses read as zero.
  assign rdMux =
    (regAddr == REG_PINS)     ? {19'h00000, pins} :
    (regAddr == REG_ADDR)     ? {14'h0000, addrReg} :
    (regAddr == REG_WDATA)    ? wdata[31:0] :
    (regAddr == REG_WDATA_HI) ? {28'h0000000, wdata[35:32]} :
    (regAddr == REG_RDATA)    ? rdataReg[31:0] :
    (regAddr == REG_RDATA_HI) ? {28'h0000000, rdataReg[35:32]} :
    (regAddr == REG_RBADDR)   ? {14'h0000, rbReg} :
    (regAddr == REG_STATUS)   ? {29'h00000000, mclrDone,
                                 link.wrapFlagN, link.mailboxFlagN} :
    32'h00000000;

  // Register writes and the read port.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins      <= PINS_RESET;
      addrReg   <= '0;
      wdata     <= '0;
      regRdData <= '0;
    end else begin
      if (wrPins)   pins <= regWrData[12:0];
      if (wrAddr)   addrReg <= regWrData[ADDR_W-1:0];
      if (wrData)   wdata[31:0] <= regWrData;
      if (wrDataHi) wdata[35:32] <= regWrData[3:0];
      regRdData <= regRd ? rdMux : 32'h00000000;
    end
  end

  // ------------------------------------------------------------------
  // Power-up master clear
  // ------------------------------------------------------------------
  // After reset the port is held in master clear for a fixed time so the
  // device never starts from an unknown counter or flag.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mclrCnt  <= '0;
      mclrDone <= 1'b0;
    end else if (!mclrDone) begin
      mclrCnt  <= mclrCnt + 8'h01;
      mclrDone <= (mclrCnt == 8'(MCLR_CYCLES - 1));
    end
  end

  // ------------------------------------------------------------------
  // Link drive
  // ------------------------------------------------------------------
  // A launch shows the pin image, less its output enable and master clear bits, for exactly one cycle, then the port
  // falls back to idle: deselected, counter holding, read direction.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.addrStrobeN   <= 1'b1;
      link.countAdvanceN <= 1'b1;
      link.counterClearN <= 1'b1;
      link.maskSelectN   <= 1'b1;
      link.readWriteN    <= 1'b1;
      link.chipSelLowN   <= 1'b1;
      link.chipSelHigh   <= 1'b0;
      link.byteLaneSelN  <= 4'hf;
      link.addrHostOe    <= 1'b0;
      link.dataHostOe    <= 1'b0;
      link.addrHost      <= '0;
      link.dataHost      <= '0;
      link.outEnableN    <= 1'b1;
      link.masterClearN  <= 1'b0;
    end else begin
      link.masterClearN  <= mclrDone && pins[PIN_MCLR];
      link.outEnableN    <= pins[PIN_OE];
      link.addrHost      <= addrReg;
      link.dataHost      <= wdata;
      link.addrStrobeN   <= go ? pins[PIN_STROBE] : 1'b1;
      link.countAdvanceN <= go ? pins[PIN_ADVANCE] : 1'b1;
      link.counterClearN <= go ? pins[PIN_CLEAR] : 1'b1;
      link.maskSelectN   <= go ? pins[PIN_MASKSEL] : 1'b1;
      link.readWriteN    <= go ? pins[PIN_RW] : 1'b1;
      link.chipSelLowN   <= go ? pins[PIN_CSLOW] : 1'b1;
      link.chipSelHigh   <= go && pins[PIN_CSHIGH];
      link.byteLaneSelN  <= go ? pins[PIN_LANE +: 4] : 4'hf;
      // The address pins are ours only when the strobe is used, which
      // leaves them free for the device's readback the cycle after.
      link.addrHostOe    <= go && !pins[PIN_STROBE];
      link.dataHostOe    <= go && !pins[PIN_RW];
    end
  end

  // Capture whatever the device drives back.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdataReg <= '0;
      rbReg    <= '0;
    end else begin
      if (link.dataDevOe) rdataReg <= link.dataBus;
      if (link.addrDevOe) rbReg <= link.addrBus;
    end
  end

endmodule : dpr_port_host
`default_nettype wire

/* File: dpr_link_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches one port of the link; both ends are design modules.
module dpr_link_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       addrStrobeN,
  input wire logic       chipSelLowN,
  input wire logic       chipSelHigh,
  input wire logic       countAdvanceN,
  input wire logic       counterClearN,
  input wire logic       maskSelectN,
  input wire logic       readWriteN,
  input wire logic       outEnableN,
  input wire logic [3:0] byteLaneSelN,
  input wire logic       masterClearN,
  input wire logic       mailboxFlagN,
  input wire logic       wrapFlagN,
  input wire logic       addrDevOe,
  input wire logic       dataDevOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire sel = !chipSelLowN && chipSelHigh;  // Both enables must agree.
  // Data may only be driven with output enable low, after a selected read.
  oe_gate_a: assert property (dataDevOe |-> !outEnableN &&
    $past(sel && readWriteN)) else $error("data driven without a read");
  read_drive_a: assert property (sel && readWriteN &&
    masterClearN ##1 !outEnableN && masterClearN |-> dataDevOe)
    else $error("read not driven");
  desel_drive_a: assert property (!sel |=> !dataDevOe)
    else $error("data driven while not selected");
  write_quiet_a: assert property (!readWriteN |=> !dataDevOe)
    else $error("data driven after a write");
  readback_drive_a: assert property (counterClearN && !addrStrobeN &&
    countAdvanceN && masterClearN ##1 masterClearN |-> addrDevOe)
    else $error("readback missing");
  wrap_cause_a: assert property ($fell(wrapFlagN) |->
    $past(addrStrobeN && counterClearN && !countAdvanceN && maskSelectN))
    else $error("wrap flag fell without a step");
  clear_wrap_a: assert property (!counterClearN && maskSelectN
    |=> wrapFlagN) else $error("wrap flag low after a clear");
  mbox_rel_a: assert property ($rose(mailboxFlagN) && masterClearN &&
    $past(masterClearN) |-> $past(sel && readWriteN && byteLaneSelN != 4'hf))
    else $error("mailbox flag released without a read");
  mclr_state_a: assert property (!masterClearN |-> mailboxFlagN &&
    wrapFlagN
    && !addrDevOe && !dataDevOe) else $error("master clear state wrong");
  cover property (dataDevOe);
  cover property (addrDevOe);
  cover property ($fell(wrapFlagN));
  cover property ($fell(mailboxFlagN));
endmodule : dpr_link_chk
`default_nettype wire

/* File: test_dual_port_burst_ram_port.sv */
`timescale 1ns/100ps
`default_nettype none
module test_dual_port_burst_ram_port;
  import dpr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr [2];
  logic [31:0] regWrData [2];
  logic        regWr [2];
  logic        regRd [2];
  logic [31:0] regRdData [2];
  logic [35:0] d0, d1;
  logic [17:0] a;
  logic [3:0]  ln;
  int          bad_count = 0, compares = 0, seed = 24;
  dpr_if port [2] ();
  dpr_ram_device dpr_ram_device_i (.sys_clk(sys_clk), .rst(rst),
    .leftPort(port[0]), .rightPort(port[1]));
  for (genvar g = 0; g < 2; g++) begin : h
    dpr_port_host dpr_port_host_i (.sys_clk(sys_clk), .rst(rst),
      .regAddr(regAddr[g]), .regWrData(regWrData[g]), .regWr(regWr[g]),
      .regRd(regRd[g]), .regRdData(regRdData[g]), .link(port[g]));
  end
  dpr_link_chk dpr_link_chk_i (.sys_clk(sys_clk), .rst(rst),
    .addrStrobeN(port[0].addrStrobeN), .chipSelLowN(port[0].chipSelLowN),
    .chipSelHigh(port[0].chipSelHigh), .countAdvanceN(port[0].countAdvanceN),
    .counterClearN(port[0].counterClearN), .maskSelectN(port[0].maskSelectN),
    .readWriteN(port[0].readWriteN), .outEnableN(port[0].outEnableN),
    .byteLaneSelN(port[0].byteLaneSelN), .masterClearN(port[0].masterClearN),
    .mailboxFlagN(port[0].mailboxFlagN), .wrapFlagN(port[0].wrapFlagN),
    .addrDevOe(port[0].addrDevOe), .dataDevOe(port[0].dataDevOe));
  always #2.5 sys_clk = ~sys_clk;
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic wr(input int p, input logic [7:0] ad, input logic [31:0] d);
    regAddr[p] <= ad;
    regWrData[p] <= d;
    regWr[p] <= 1'b1;
    @(posedge sys_clk);
    regWr[p] <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input int p, input logic [7:0] ad,
                    input logic [31:0] m, e);
    regAddr[p] <= ad;
    regRd[p] <= 1'b1;
    @(posedge sys_clk);
    regRd[p] <= 1'b0;
    #1;
    compares++;
    if ((regRdData[p] & m) !== e)
      $display("BAD %0t got %h exp %h", $time, regRdData[p] & m, e);
    if ((regRdData[p] & m) !== e)
      bad_count++;
    @(posedge sys_clk);
  endtask : rd
  // One pin image launched through the go register, then settled.
  task automatic op(input int p, input logic [12:0] pv, input logic [17:0] ad,
                    input logic [35:0] d);
    wr(p, REG_PINS, 32'(pv));
    wr(p, REG_ADDR, 32'(ad));
    wr(p, REG_WDATA, d[31:0]);
    wr(p, REG_WDATA_HI, 32'(d[35:32]));
    wr(p, REG_GO, 32'h1);
    repeat (4) @(posedge sys_clk);
  endtask : op
  // Lanes whose select is low take the new word.
  function automatic logic [35:0] merge(input logic [35:0] o, n,
                                        input logic [3:0] s);
    for (int l = 0; l < 4; l++)
      merge[9*l+:9] = s[l] ? o[9*l+:9] : n[9*l+:9];
  endfunction : merge
  initial begin
    for (int p = 0; p < 2; p++) begin
      regWr[p] = 1'b0;
      regRd[p] = 1'b0;
      regAddr[p] = 8'h00;
      regWrData[p] = 32'h0;
    end
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (MCLR_CYCLES + 5) @(posedge sys_clk);
    rd(0, REG_STATUS, 32'h7, 32'h7);
    rd(0, 8'h40, 32'hffffffff, 32'h0);
    for (int i = 0; i < 6; i++) begin
      a = 18'($random(seed)) & 18'h1ffff;
      d0 = {4'($random(seed)), 32'($random(seed))};
      d1 = {4'($random(seed)), 32'($random(seed))};
      ln = 4'($random(seed));
      op(i % 2, 13'h182c, a, d0);
      op(i % 2, 13'h182c | (13'(ln) << 6), a, d1);
      op(1 - i % 2, 13'h181c, a, 36'h0);
      d1 = merge(d0, d1, ln);
      rd(1 - i % 2, REG_RDATA, 32'hffffffff, d1[31:0]);
      rd(1 - i % 2, REG_RDATA_HI, 32'hf, 32'(d1[35:32]));
    end
    op(0, 13'h17f4, 18'h0000f, 36'h0);
    op(0, 13'h17f6, 18'h0, 36'h0);
    rd(0, REG_RBADDR, 32'h3ffff, 32'h0000f);
    op(0, 13'h17fc, 18'h00a5e, 36'h0);
    op(0, 13'h17fd, 18'h0, 36'h0);
    op(0, 13'h17fe, 18'h0, 36'h0);
    rd(0, REG_RBADDR, 32'h3ffff, 32'h00a5f);
    rd(0, REG_STATUS, 32'h2, 32'h0);
    op(0, 13'h17f8, 18'h01234, 36'h0);
    op(0, 13'h17fe, 18'h0, 36'h0);
    rd(0, REG_RBADDR, 32'h3ffff, 32'h00a50);
    op(1, 13'h182c, MBOX_LEFT, 36'h5a);
    rd(0, REG_STATUS, 32'h1, 32'h0);
    // A read with only one chip enable asserted must not release the flag.
    op(0, 13'h101c, MBOX_LEFT, 36'h0);
    rd(0, REG_STATUS, 32'h1, 32'h0);
    op(0, 13'h181c, MBOX_LEFT, 36'h0);
    rd(0, REG_STATUS, 32'h1, 32'h1);
    // Mid-run master clear: flags, counter and mask go back to reset.
    op(1, 13'h182c, MBOX_LEFT, 36'h5a);
    wr(0, REG_PINS, 32'h0fff);
    wr(0, REG_PINS, 32'h1fff);
    rd(0, REG_STATUS, 32'h7, 32'h7);
    op(0, 13'h17f6, 18'h0, 36'h0);
    rd(0, REG_RBADDR, 32'h3ffff, 32'h3ffff);
    op(0, 13'h17fe, 18'h0, 36'h0);
    rd(0, REG_RBADDR, 32'h3ffff, 32'h0);
    report_and_stop();
  end
  // The sequence needs some five hundred cycles; this is far past it.
  initial begin
    #100us;
    bad_count++;
    report_and_stop();
  end
endmodule : test_dual_port_burst_ram_port
`default_nettype wire
